// ==== tb/testbench.sv ====
// Purpose: self-checking bench for tpoc_top
// Assumes: partner model drives the clear and trigger pins
// Notes: widths counted on channel 0
`timescale 1ns/10ps
`default_nettype none
module testbench
  import tpoc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] pa = 8'h0;
  logic [31:0] pwd = 32'h0, prd, rdq;
  logic rdy, slv, irq, dma, run, clr_p, ext_p, ch2_p, errq;
  logic [3:0] ref_o, ch, chn, itr;
  int err_count = 0, samples_checked = 0, cyc = 0, dma_cnt = 0;
  int dly, wid, w1;
  tpoc_partner p (.clk_in(clk), .clear_out(clr_p), .ext_out(ext_p),
    .ch2_out(ch2_p), .itr_out(itr));
  tpoc_top #(.N_CH(4), .CNT_W(16)) uut (
    .SYS_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
    .PREADY_OUT(rdy), .PSLVERR_OUT(slv), .CLEAR_IN(clr_p),
    .EXT_TRIG_FILT_IN(ext_p), .CH2_FILT_IN(ch2_p), .ITR_IN(itr),
    .REF_OUT(ref_o), .CH_OUT(ch), .CHN_OUT(chn), .COM_IRQ_OUT(irq),
    .COM_DMA_OUT(dma), .RUN_OUT(run));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // verdict and end of run
  task automatic end_sim();
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // one apb transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // no timeout of its own; only the watchdog ends a wait that never sees ready
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    rdq = prd;
    errq = slv;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic trig(input int s);
    p.drive(s, 1'b1);
    p.drive(s, 1'b0);
  endtask : trig
  // delay from run to reference rise, then high width
  task automatic meas(output int d, output int w);
    int n;
    n = 0;
    d = 0;
    w = 0;
    while (run !== 1'b1 && n < 99) begin
      @(posedge clk);
      n++;
    end
    while (ref_o[0] !== 1'b1 && d < 99) begin
      @(posedge clk);
      d++;
    end
    while (ref_o[0] === 1'b1 && w < 99) begin
      @(posedge clk);
      w++;
    end
  endtask : meas
  // watchdog and dma pulse count
  always @(posedge clk) begin
    cyc++;
    if (dma === 1'b1) begin
      dma_cnt++;
    end
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, TPOC_ARR_OFS, 32'h0);
    chk(rdq, 32'hffff);
    apb(1'b0, 8'hfc, 32'h0);
    chk({errq, rdq[30:0]}, 32'h8000_0000);
    // single pulse, pwm mode 2, then fast enable
    wr(TPOC_ARR_OFS, 32'hc);
    wr(TPOC_CCR0_OFS, 32'h5);
    wr(TPOC_CHEN_OFS, 32'h1);
    wr(TPOC_SMODE_OFS, 32'h66);
    wr(TPOC_CTRL_OFS, 32'h8);
    for (int f = 0; f < 2; f++) begin
      wr(TPOC_CHMODE_OFS, f ? 32'hf : 32'h7);
      fork
        trig(2);
        meas(dly, wid);
      join
      tick(5);
      chk(run, 0);
      if (f == 0) begin
        // reference is registered one clock behind the count
        chk(dly, 32'h5 + 32'h1);
        chk(wid, 7);
      end else begin
        chk(dly < 2, 1);
      end
    end
    // full duty pwm mode 1 with clear
    wr(TPOC_CCR0_OFS, 32'h14);
    wr(TPOC_SMODE_OFS, 32'h0);
    wr(TPOC_CHMODE_OFS, 32'h16);
    wr(TPOC_CTRL_OFS, 32'h1);
    tick(20);
    chk(ref_o[0], 1);
    p.drive(0, 1'b1);
    tick(6);
    chk(ref_o[0], 0);
    p.drive(0, 1'b0);
    tick(30);
    chk({run, ref_o[0]}, 2'h3);
    wr(TPOC_SMODE_OFS, 32'h8);
    p.drive(0, 1'b1);
    tick(6);
    chk(ref_o[0], 1);
    p.drive(0, 1'b0);
    p.drive(1, 1'b1);
    tick(6);
    chk(ref_o[0], 0);
    p.drive(1, 1'b0);
    tick(30);
    wr(TPOC_CHMODE_OFS, 32'h15);
    p.drive(1, 1'b1);
    tick(6);
    chk(ref_o[0], 1);
    p.drive(1, 1'b0);
    // retriggerable pulse, combined slave mode
    wr(TPOC_CTRL_OFS, 32'h0);
    wr(TPOC_ARR_OFS, 32'ha);
    wr(TPOC_CCR0_OFS, 32'h0);
    wr(TPOC_SMODE_OFS, 32'h10060);
    wr(TPOC_CHMODE_OFS, 32'h20);
    fork
      trig(2);
      meas(dly, w1);
    join
    tick(20);
    fork
      begin
        trig(2);
        tick(3);
        trig(2);
      end
      meas(dly, wid);
    join
    chk(wid - w1, 5);
    wr(TPOC_CHMODE_OFS, 32'h21);
    tick(20);
    chk(ref_o[0], 1);
    trig(2);
    tick(4);
    chk(ref_o[0], 0);
    tick(20);
    // preloaded commutation by software then trigger
    wr(TPOC_SMODE_OFS, 32'h0);
    wr(TPOC_CHEN_OFS, 32'h0);
    wr(TPOC_CR2_OFS, 32'h5);
    wr(TPOC_CHMODE_OFS, 32'h5);
    wr(TPOC_CHEN_OFS, 32'h1);
    wr(TPOC_IEN_OFS, 32'h2020);
    tick(3);
    chk(ch[0], 0);
    wr(TPOC_EVGEN_OFS, 32'h20);
    tick(3);
    chk({irq, ch[0]}, 2'h3);
    apb(1'b0, TPOC_STATUS_OFS, 32'h0);
    chk(rdq & 32'h20, 32'h20);
    wr(TPOC_STATUS_OFS, 32'h0);
    wr(TPOC_CHMODE_OFS, 32'h4);
    wr(TPOC_CHEN_OFS, 32'h5);
    p.drive(3, 1'b1);
    tick(6);
    chk(chn[0], 1);
    chk(dma_cnt, 2);
    p.drive(3, 1'b0);
    end_sim();
  end
endmodule : testbench
`default_nettype wire

// ==== tb/tpoc_assertions.sv ====
// Purpose: port-level checks for tpoc_top
// Assumes: zero-wait apb answers
// Notes: bound into every tpoc_top
`timescale 1ns/10ps
`default_nettype none
module tpoc_assertions
  import tpoc_pkg::*;
#(
  parameter int N_CH = 4 // channel count
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic [N_CH-1:0] CH_OUT,
  input wire logic [N_CH-1:0] CHN_OUT,
  input wire logic COM_DMA_OUT,
  input wire logic RUN_OUT
);
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (RST_IN);
  // apb answer timing
  ready_after_setup_a: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
    else $error("ready missing");
  ready_single_a: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready too long");
  ready_cause_a: assert property (PREADY_OUT |-> $past(PSEL_IN && !PENABLE_IN))
    else $error("ready without setup");
  err_with_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error without ready");
  rdata_idle_a: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0)
    else $error("stray read data");
  // commutation request and output pair
  dma_pulse_a: assert property (COM_DMA_OUT |=> !COM_DMA_OUT)
    else $error("dma pulse too long");
  outs_apart_a: assert property ((CH_OUT & CHN_OUT) == '0)
    else $error("both outputs high");
  reset_quiet_a: assert property (disable iff (1'b0) RST_IN |=> !RUN_OUT && !PREADY_OUT)
    else $error("active after reset");
  cover property (COM_DMA_OUT);
  cover property ($fell(RUN_OUT));
  cover property (PSLVERR_OUT);
endmodule : tpoc_assertions
bind tpoc_top tpoc_assertions #(.N_CH(N_CH)) u_chk (
  .SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .CH_OUT(CH_OUT), .CHN_OUT(CHN_OUT),
  .COM_DMA_OUT(COM_DMA_OUT), .RUN_OUT(RUN_OUT)
);
`default_nettype wire

// ==== tb/tpoc_partner.sv ====
// Purpose: trigger and clear sources at the pins
// Assumes: levels change just after a rising edge
// Notes: always driven, no pulls
`timescale 1ns/10ps
`default_nettype none
module tpoc_partner (
  input wire logic clk_in,
  output logic clear_out, // dedicated clear level
  output logic ext_out, // filtered external trigger
  output logic ch2_out, // filtered channel 2 input
  output logic [3:0] itr_out // internal triggers
);
  // all sources idle low
  initial begin
    clear_out = 1'b0;
    ext_out = 1'b0;
    ch2_out = 1'b0;
    itr_out = 4'h0;
  end
  // set one source level after the next edge
  task automatic drive(input int s, input logic v);
    @(posedge clk_in);
    case (s)
      0: clear_out <= v;
      1: ext_out <= v;
      2: ch2_out <= v;
      default: itr_out <= {3'h0, v};
    endcase
  endtask : drive
endmodule : tpoc_partner
`default_nettype wire

// ==== verilog/tpoc_chan_ref.sv ====
// Purpose: reference waveform of one timer channel
// Assumes: up-counting counter, pulses from the same clock domain
// Notes: reference output is registered
`timescale 1ns/10ps
`default_nettype none
module tpoc_chan_ref
  import tpoc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] mode_in, // active output mode
  input wire logic fast_en_in, // fast output enable
  input wire logic clr_en_in, // ref_clear_enable
  input wire logic clr_in, // selected clear level, synchronised
  input wire logic run_in, // counter running
  input wire logic [CNT_W-1:0] cnt_in,
  input wire logic [CNT_W-1:0] ccr_in,
  input wire logic upd_in, // update_event pulse
  input wire logic trig_in, // trigger edge pulse
  output logic ref_out // channel_reference_wave
);
  logic ref_q; // registered reference
  logic oc_q; // compare-mode level
  logic clr_q; // clear latch
  logic fast_q; // fast enable jump in effect
  logic rop_q; // retriggerable pulse in progress
  // mode decode
  wire forced = (mode_in == TPOC_OM_FORCE_LOW) || (mode_in == TPOC_OM_FORCE_HIGH);
  wire is_pwm = (mode_in == TPOC_OM_PWM1) || (mode_in == TPOC_OM_PWM2);
  wire is_rop = (mode_in == TPOC_OM_ROPM1) || (mode_in == TPOC_OM_ROPM2);
  wire match = run_in && (cnt_in == ccr_in);
  wire below = cnt_in < ccr_in; // pwm1 active region
  // clear latch: forced modes ignore it, update releases it
  wire clr_set = clr_en_in && clr_in && !forced;
  wire clr_d = clr_set || (clr_q && !upd_in);
  // fast jump: taken at trigger, natural compare takes over at match
  wire fast_d = (trig_in && fast_en_in && is_pwm) || (fast_q && !upd_in && !match);
  // retriggerable pulse: trigger starts or extends, update ends
  wire rop_d = (trig_in && is_rop) || (rop_q && !upd_in);
  logic oc_d;
  logic raw;
  // compare-mode level on match
  always_comb begin
    oc_d = oc_q;
    if (match) begin
      case (mode_in)
        TPOC_OM_ACT_MATCH: oc_d = 1'b1; // set on match
        TPOC_OM_INACT_MATCH: oc_d = 1'b0; // clear on match
        TPOC_OM_TOGGLE: oc_d = !oc_q; // toggle on match
        default: oc_d = oc_q; // hold
      endcase
    end
  end
  // raw reference per mode before clearing
  always_comb begin
    case (mode_in)
      TPOC_OM_FORCE_LOW: raw = 1'b0; // forced inactive
      TPOC_OM_FORCE_HIGH: raw = 1'b1; // forced active
      TPOC_OM_PWM1: raw = fast_d ? 1'b0 : below;
      // pwm2 drops in the cycle the count sits at reload, so width is reload minus compare
      TPOC_OM_PWM2: raw = fast_d ? 1'b1 : (!below && !upd_in);
      TPOC_OM_ROPM1: raw = rop_d;
      TPOC_OM_ROPM2: raw = !rop_d; // inverted pulse
      default: raw = oc_d; // compare modes and frozen
    endcase
  end
  // state registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ref_q <= 1'b0;
      oc_q <= 1'b0;
      clr_q <= 1'b0;
      fast_q <= 1'b0;
      rop_q <= 1'b0;
    end else begin
      ref_q <= raw && !clr_d;
      oc_q <= oc_d;
      clr_q <= clr_d;
      fast_q <= fast_d;
      rop_q <= rop_d;
    end
  end
  assign ref_out = ref_q;
endmodule : tpoc_chan_ref
`default_nettype wire

// ==== verilog/tpoc_pkg.sv ====
// Purpose: shared constants for the timer pulse output control block
// Assumes: APB register map with 32-bit aligned words, up to four channels
// Notes: offsets are byte addresses; field positions and codes live here
// Overview of operation
// - clear input low-drives reference until update
// - clear acts in compare/PWM, never forced
// - select bit picks dedicated or filtered trigger
// - full-duty reference returns at next overflow
// - modes and enables preloaded, moved together
// - commutation by software bit or trigger rise
// - commutation sets flag, interrupt, DMA request
// - single-pulse select stops counter at update
// - single-pulse clear keeps counter running repetitively
// - slave code 110 trigger, source 00110 ch2
// - trigger edge sets counter run enable
// - delay equals compare, width reload minus compare
// - mode 111 high on match, low at reload
// - fast enable jumps reference at trigger
// - retriggerable pulse starts at trigger, extends
// - slave code 1000, modes 1000/1001
// - four-bit mode fields stored split MSB
package tpoc_pkg;
  // register byte offsets
  localparam logic [7:0] TPOC_CTRL_OFS = 8'h00;
  localparam logic [7:0] TPOC_SMODE_OFS = 8'h04;
  localparam logic [7:0] TPOC_STATUS_OFS = 8'h08;
  localparam logic [7:0] TPOC_EVGEN_OFS = 8'h0c;
  localparam logic [7:0] TPOC_IEN_OFS = 8'h10;
  localparam logic [7:0] TPOC_CHMODE_OFS = 8'h14;
  localparam logic [7:0] TPOC_CHEN_OFS = 8'h18;
  localparam logic [7:0] TPOC_CR2_OFS = 8'h1c;
  localparam logic [7:0] TPOC_ARR_OFS = 8'h20;
  localparam logic [7:0] TPOC_CNT_OFS = 8'h24;
  localparam logic [7:0] TPOC_CCR0_OFS = 8'h28;
  localparam logic [7:0] TPOC_ACTIVE_OFS = 8'h38;
  // control fields
  localparam int TPOC_CEN_BIT = 0;
  localparam int TPOC_OPM_BIT = 3;
  localparam int TPOC_CMS_LSB = 5;
  // slave mode fields, mode code split over two places
  localparam int TPOC_SMS_LSB = 0;
  localparam int TPOC_CLEAR_SOURCE_SELECT_BIT = 3;
  localparam int TPOC_TS_LSB = 4;
  localparam int TPOC_ETF_LSB = 8;
  localparam int TPOC_EXT_TRIGGER_PRESCALER_LSB = 12;
  localparam int TPOC_ECE_BIT = 14;
  localparam int TPOC_ETP_BIT = 15;
  localparam int TPOC_SMS_MSB_BIT = 16;
  localparam int TPOC_TS_HI_LSB = 20;
  // status, event, enable and cr2 bits
  localparam int TPOC_COM_BIT = 5;
  localparam int TPOC_UG_BIT = 0;
  localparam int TPOC_PHASE_SWITCH_DMA_ENABLE_BIT = 13;
  localparam int TPOC_CCPC_BIT = 0;
  localparam int TPOC_CCUS_BIT = 2;
  // per-channel byte in the channel mode word
  localparam int TPOC_CH_STRIDE = 8;
  localparam int TPOC_FE_OFS = 3;
  localparam int TPOC_CE_OFS = 4;
  localparam int TPOC_MMSB_OFS = 5;
  // per-channel nibble in the enable word
  localparam int TPOC_EN_STRIDE = 4;
  localparam int TPOC_NEN_OFS = 2;
  // slave mode codes
  localparam logic [3:0] TPOC_SMS_RESET = 4'h4;
  localparam logic [3:0] TPOC_SMS_TRIGGER = 4'h6;
  localparam logic [3:0] TPOC_SMS_COMBINED = 4'h8;
  // trigger source codes
  localparam logic [4:0] TPOC_TS_CH2 = 5'h06;
  localparam logic [4:0] TPOC_TS_EXT = 5'h07;
  // reset values
  localparam logic [15:0] TPOC_ARR_RST = 16'hffff;
  // channel output mode codes
  typedef enum logic [3:0] {
    TPOC_OM_FROZEN = 4'b0000,
    TPOC_OM_ACT_MATCH = 4'b0001,
    TPOC_OM_INACT_MATCH = 4'b0010,
    TPOC_OM_TOGGLE = 4'b0011,
    TPOC_OM_FORCE_LOW = 4'b0100,
    TPOC_OM_FORCE_HIGH = 4'b0101,
    TPOC_OM_PWM1 = 4'b0110,
    TPOC_OM_PWM2 = 4'b0111,
    TPOC_OM_ROPM1 = 4'b1000,
    TPOC_OM_ROPM2 = 4'b1001
  } tpoc_mode_e;
endpackage : tpoc_pkg

// ==== verilog/tpoc_top.sv ====
// Purpose: timer channel output shaping with APB registers
// Assumes: up-counting edge-aligned counter, pins synchronised here
// Notes: no dead time; complementary output is the inverted reference
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module tpoc_top
  import tpoc_pkg::*;
#(
  parameter int N_CH = 4, // channels, at most four
  parameter int CNT_W = 16 // counter width
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic CLEAR_IN, // dedicated clear input pin
  input wire logic EXT_TRIG_FILT_IN, // filtered_ext_trigger
  input wire logic CH2_FILT_IN, // ch2_filtered_input
  input wire logic [3:0] ITR_IN, // internal trigger sources
  output logic [N_CH-1:0] REF_OUT, // channel_reference_wave
  output logic [N_CH-1:0] CH_OUT, // main outputs
  output logic [N_CH-1:0] CHN_OUT, // complementary outputs
  output logic COM_IRQ_OUT, // commutation interrupt level
  output logic COM_DMA_OUT, // commutation dma request pulse
  output logic RUN_OUT // counter_run_enable
);
  // two-flop synchronisers for pins
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  logic trg_prev_q; // selected trigger, last cycle
  // control state
  logic cen_q; // counter_run_enable
  logic opm_q; // single_pulse_select
  logic [1:0] cms_q; // center_align_select, stored only
  logic [3:0] sms_q; // slave_mode_select
  logic clear_source_select_q; // clear_source_select
  logic [4:0] ts_q; // trigger_source_select
  logic [3:0] etf_q; // ext_trigger_filter, stored only
  logic [1:0] ext_trigger_prescaler_q; // ext_trigger_prescaler, stored only
  logic ece_q; // ext_clock_mode2_enable, stored only
  logic etp_q; // ext_trigger_polarity, stored only
  logic com_flag_q; // phase_switch_flag
  logic com_ie_q; // phase_switch_irq_enable
  logic com_de_q; // phase_switch_dma_enable
  logic ccpc_q; // preload of modes and enables on
  logic ccus_q; // trigger rise may commutate
  logic [CNT_W-1:0] arr_q; // auto_reload_value
  logic [CNT_W-1:0] cnt_q; // counter_value
  logic [CNT_W-1:0] ccr_q [N_CH]; // compare_value per channel
  // preloaded and active copies of the channel modes and enables; fast and clear enables have one copy
  logic [3:0] pre_mode_q [N_CH];
  logic [3:0] act_mode_q [N_CH];
  logic [N_CH-1:0] fe_q; // fast_output_enable
  logic [N_CH-1:0] ce_q; // ref_clear_enable
  logic [N_CH-1:0] pre_en_q; // channel_output_enable, preload
  logic [N_CH-1:0] pre_nen_q; // complementary_output_enable, preload
  logic [N_CH-1:0] act_en_q;
  logic [N_CH-1:0] act_nen_q;
  // bus and output flops
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic irq_q;
  logic dma_q;
  logic [N_CH-1:0] ch_q;
  logic [N_CH-1:0] chn_q;
  wire [N_CH-1:0] ref_w;

  // word-address match helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction : hit

  // synchronised pin levels
  wire clr_pin_s = sync2_q[0];
  wire etr_s = sync2_q[1];
  wire ch2_s = sync2_q[2];
  wire [3:0] itr_s = sync2_q[6:3];
  // clear source selection
  wire clr_sel = clear_source_select_q ? etr_s : clr_pin_s;
  // trigger source selection, ch2 filtered at 00110
  wire trg_sel = (ts_q == TPOC_TS_CH2) ? ch2_s :
                 (ts_q == TPOC_TS_EXT) ? etr_s :
                 (ts_q[4:2] == 3'b000) ? itr_s[ts_q[1:0]] : 1'b0;
  wire trig_edge = trg_sel && !trg_prev_q;
  // slave mode decode
  wire sm_trig = (sms_q == TPOC_SMS_TRIGGER);
  wire sm_reset = (sms_q == TPOC_SMS_RESET);
  wire sm_comb = (sms_q == TPOC_SMS_COMBINED);
  wire hw_start = trig_edge && (sm_trig || sm_comb);
  wire hw_restart = trig_edge && (sm_reset || sm_comb);

  // bus decode
  wire setup = PSEL_IN && !PENABLE_IN;
  wire access = PSEL_IN && PENABLE_IN && pready_q;
  wire [7:0] ccr_end = TPOC_CCR0_OFS + 8'(4 * N_CH);
  wire is_ccr = (PADDR_IN >= TPOC_CCR0_OFS) && (PADDR_IN < ccr_end);
  wire [1:0] ccr_idx = 2'((PADDR_IN - TPOC_CCR0_OFS) >> 2);
  wire mapped = hit(PADDR_IN, TPOC_CTRL_OFS) || hit(PADDR_IN, TPOC_SMODE_OFS) ||
                hit(PADDR_IN, TPOC_STATUS_OFS) || hit(PADDR_IN, TPOC_EVGEN_OFS) ||
                hit(PADDR_IN, TPOC_IEN_OFS) || hit(PADDR_IN, TPOC_CHMODE_OFS) ||
                hit(PADDR_IN, TPOC_CHEN_OFS) || hit(PADDR_IN, TPOC_CR2_OFS) ||
                hit(PADDR_IN, TPOC_ARR_OFS) || hit(PADDR_IN, TPOC_CNT_OFS) ||
                hit(PADDR_IN, TPOC_ACTIVE_OFS) || is_ccr;
  wire wr = access && PWRITE_IN && !pslverr_q;
  wire wr_ctrl = wr && hit(PADDR_IN, TPOC_CTRL_OFS);
  wire wr_smode = wr && hit(PADDR_IN, TPOC_SMODE_OFS);
  wire wr_status = wr && hit(PADDR_IN, TPOC_STATUS_OFS);
  wire wr_evgen = wr && hit(PADDR_IN, TPOC_EVGEN_OFS);
  wire wr_ien = wr && hit(PADDR_IN, TPOC_IEN_OFS);
  wire wr_chmode = wr && hit(PADDR_IN, TPOC_CHMODE_OFS);
  wire wr_chen = wr && hit(PADDR_IN, TPOC_CHEN_OFS);
  wire wr_cr2 = wr && hit(PADDR_IN, TPOC_CR2_OFS);
  wire wr_arr = wr && hit(PADDR_IN, TPOC_ARR_OFS);
  wire wr_cnt = wr && hit(PADDR_IN, TPOC_CNT_OFS);
  wire wr_ccr = wr && is_ccr;

  // events
  wire ug_evt = wr_evgen && PWDATA_IN[TPOC_UG_BIT];
  wire overflow = cen_q && (cnt_q == arr_q);
  wire upd = overflow || ug_evt || hw_restart; // update_event
  wire com_evt = (wr_evgen && PWDATA_IN[TPOC_COM_BIT]) || (ccus_q && trig_edge);
  wire com_clr = wr_status && !PWDATA_IN[TPOC_COM_BIT];
  wire com_flag_d = com_evt || (com_flag_q && !com_clr);
  wire xfer = com_evt || !ccpc_q;

  // packed views of the channel configuration
  logic [31:0] chmode_word;
  logic [31:0] chen_word;
  logic [31:0] active_word;
  always_comb begin
    chmode_word = 32'h0;
    chen_word = 32'h0;
    active_word = 32'h0;
    for (int i = 0; i < N_CH; i++) begin
      chmode_word[i*TPOC_CH_STRIDE +: 3] = pre_mode_q[i][2:0];
      chmode_word[i*TPOC_CH_STRIDE + TPOC_FE_OFS] = fe_q[i];
      chmode_word[i*TPOC_CH_STRIDE + TPOC_CE_OFS] = ce_q[i];
      chmode_word[i*TPOC_CH_STRIDE + TPOC_MMSB_OFS] = pre_mode_q[i][3];
      chen_word[i*TPOC_EN_STRIDE] = pre_en_q[i];
      chen_word[i*TPOC_EN_STRIDE + TPOC_NEN_OFS] = pre_nen_q[i];
      active_word[i*TPOC_CH_STRIDE +: 4] = act_mode_q[i];
      active_word[i*TPOC_CH_STRIDE + 4] = act_en_q[i];
      active_word[i*TPOC_CH_STRIDE + 5] = act_nen_q[i];
      active_word[i*TPOC_CH_STRIDE + 6] = ref_w[i];
    end
  end

  // read data selection
  wire [31:0] ctrl_word = {25'h0, cms_q, 1'b0, opm_q, 2'b00, cen_q};
  wire [31:0] smode_word = {10'h0, ts_q[4:3], 3'h0, sms_q[3], etp_q, ece_q, ext_trigger_prescaler_q,
                            etf_q, 1'b0, ts_q[2:0], clear_source_select_q, sms_q[2:0]};
  wire [31:0] status_word = 32'(com_flag_q) << TPOC_COM_BIT;
  wire [31:0] ien_word = (32'(com_ie_q) << TPOC_COM_BIT) | (32'(com_de_q) << TPOC_PHASE_SWITCH_DMA_ENABLE_BIT);
  wire [31:0] cr2_word = (32'(ccpc_q) << TPOC_CCPC_BIT) | (32'(ccus_q) << TPOC_CCUS_BIT);
  wire [31:0] rdata =
    hit(PADDR_IN, TPOC_CTRL_OFS) ? ctrl_word :
    hit(PADDR_IN, TPOC_SMODE_OFS) ? smode_word :
    hit(PADDR_IN, TPOC_STATUS_OFS) ? status_word :
    hit(PADDR_IN, TPOC_IEN_OFS) ? ien_word :
    hit(PADDR_IN, TPOC_CHMODE_OFS) ? chmode_word :
    hit(PADDR_IN, TPOC_CHEN_OFS) ? chen_word :
    hit(PADDR_IN, TPOC_CR2_OFS) ? cr2_word :
    hit(PADDR_IN, TPOC_ARR_OFS) ? 32'(arr_q) :
    hit(PADDR_IN, TPOC_CNT_OFS) ? 32'(cnt_q) :
    hit(PADDR_IN, TPOC_ACTIVE_OFS) ? active_word :
    is_ccr ? 32'(ccr_q[ccr_idx]) : 32'h0; // event register reads zero

  // apb slave: answer decided in setup, pready in the access cycle
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      prdata_q <= (setup && !PWRITE_IN && mapped) ? rdata : 32'h0;
    end
  end

  // pin synchronisers and trigger history
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
      trg_prev_q <= 1'b0;
    end else begin
      sync1_q <= {ITR_IN, CH2_FILT_IN, EXT_TRIG_FILT_IN, CLEAR_IN};
      sync2_q <= sync1_q;
      trg_prev_q <= trg_sel;
    end
  end

  // counter run enable: trigger start wins over stop and write
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      cen_q <= 1'b0;
    end else if (hw_start) begin
      cen_q <= 1'b1;
    end else if (overflow && opm_q) begin
      cen_q <= 1'b0;
    end else if (wr_ctrl) begin
      cen_q <= PWDATA_IN[TPOC_CEN_BIT];
    end
  end

  // counter: wraps at reload, restarted by software update or by a reset-mode or combined-mode trigger
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      cnt_q <= '0;
    end else if (ug_evt || hw_restart) begin
      cnt_q <= '0;
    end else if (wr_cnt) begin
      cnt_q <= PWDATA_IN[CNT_W-1:0];
    end else if (overflow) begin
      cnt_q <= '0;
    end else if (cen_q) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // control and slave mode registers
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      opm_q <= 1'b0;
      cms_q <= 2'b00;
      {sms_q, clear_source_select_q, ts_q, etf_q, ext_trigger_prescaler_q, ece_q, etp_q} <= '0;
    end else begin
      if (wr_ctrl) begin
        opm_q <= PWDATA_IN[TPOC_OPM_BIT];
        cms_q <= PWDATA_IN[TPOC_CMS_LSB +: 2];
      end
      if (wr_smode) begin
        sms_q <= {PWDATA_IN[TPOC_SMS_MSB_BIT], PWDATA_IN[TPOC_SMS_LSB +: 3]};
        clear_source_select_q <= PWDATA_IN[TPOC_CLEAR_SOURCE_SELECT_BIT];
        ts_q <= {PWDATA_IN[TPOC_TS_HI_LSB +: 2], PWDATA_IN[TPOC_TS_LSB +: 3]};
        etf_q <= PWDATA_IN[TPOC_ETF_LSB +: 4];
        ext_trigger_prescaler_q <= PWDATA_IN[TPOC_EXT_TRIGGER_PRESCALER_LSB +: 2];
        ece_q <= PWDATA_IN[TPOC_ECE_BIT];
        etp_q <= PWDATA_IN[TPOC_ETP_BIT];
      end
    end
  end

  // commutation flag, enables and outputs
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      com_flag_q <= 1'b0;
      {com_ie_q, com_de_q, ccpc_q, ccus_q} <= 4'h0;
      irq_q <= 1'b0;
      dma_q <= 1'b0;
    end else begin
      com_flag_q <= com_flag_d;
      if (wr_ien) begin
        com_ie_q <= PWDATA_IN[TPOC_COM_BIT];
        com_de_q <= PWDATA_IN[TPOC_PHASE_SWITCH_DMA_ENABLE_BIT];
      end
      if (wr_cr2) begin
        ccpc_q <= PWDATA_IN[TPOC_CCPC_BIT];
        ccus_q <= PWDATA_IN[TPOC_CCUS_BIT];
      end
      irq_q <= com_flag_d && com_ie_q;
      dma_q <= com_evt && com_de_q;
    end
  end

  // reload, compare and channel configuration
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      arr_q <= CNT_W'(TPOC_ARR_RST);
      for (int i = 0; i < N_CH; i++) begin
        ccr_q[i] <= '0;
        pre_mode_q[i] <= 4'h0;
        act_mode_q[i] <= 4'h0;
      end
      {fe_q, ce_q, pre_en_q, pre_nen_q, act_en_q, act_nen_q} <= '0;
    end else begin
      if (wr_arr) arr_q <= PWDATA_IN[CNT_W-1:0];
      if (wr_ccr) ccr_q[ccr_idx] <= PWDATA_IN[CNT_W-1:0];
      for (int i = 0; i < N_CH; i++) begin
        if (wr_chmode) begin
          pre_mode_q[i] <= {PWDATA_IN[i*TPOC_CH_STRIDE + TPOC_MMSB_OFS],
                            PWDATA_IN[i*TPOC_CH_STRIDE +: 3]};
          fe_q[i] <= PWDATA_IN[i*TPOC_CH_STRIDE + TPOC_FE_OFS];
          ce_q[i] <= PWDATA_IN[i*TPOC_CH_STRIDE + TPOC_CE_OFS];
        end
        if (wr_chen) begin
          pre_en_q[i] <= PWDATA_IN[i*TPOC_EN_STRIDE];
          pre_nen_q[i] <= PWDATA_IN[i*TPOC_EN_STRIDE + TPOC_NEN_OFS];
        end
        if (xfer) begin
          act_mode_q[i] <= pre_mode_q[i];
          act_en_q[i] <= pre_en_q[i];
          act_nen_q[i] <= pre_nen_q[i];
        end
      end
    end
  end

  // per-channel reference generators
  for (genvar g = 0; g < N_CH; g++) begin : g_ch
    tpoc_chan_ref #(.CNT_W(CNT_W)) u_ref (
      .clk_in(SYS_CLK_IN),
      .rst_in(RST_IN),
      .mode_in(act_mode_q[g]),
      .fast_en_in(fe_q[g]),
      .clr_en_in(ce_q[g]),
      .clr_in(clr_sel),
      .run_in(cen_q),
      .cnt_in(cnt_q),
      .ccr_in(ccr_q[g]),
      .upd_in(upd),
      .trig_in(trig_edge),
      .ref_out(ref_w[g])
    );
  end

  // gated channel outputs from the active enables
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      ch_q <= '0;
      chn_q <= '0;
    end else begin
      ch_q <= act_en_q & ref_w;
      chn_q <= act_nen_q & ~ref_w;
    end
  end

  assign PRDATA_OUT = prdata_q;
  assign PREADY_OUT = pready_q;
  assign PSLVERR_OUT = pslverr_q;
  assign REF_OUT = ref_w;
  assign CH_OUT = ch_q;
  assign CHN_OUT = chn_q;
  assign COM_IRQ_OUT = irq_q;
  assign COM_DMA_OUT = dma_q;
  assign RUN_OUT = cen_q;
endmodule : tpoc_top
`default_nettype wire
